// ==== rtl/width_match_pkg.sv ====
package width_match_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int WORD_W = 36;        // Internal memory word width
    localparam int LANE_W = 9;         // One byte lane
    localparam int HALF_W = 18;        // One half word
    localparam int LANES = 4;          // Lanes per word
    localparam int HALVES = 2;         // Halves per word

    // ------------------------------------------------------------
    // Sub-counter
    // ------------------------------------------------------------
    localparam int SUB_W = 2;                    // Sub-counter width
    localparam logic [1:0] SUB_FIRST_LE = 2'h0;  // Little endian start
    localparam logic [1:0] SUB_FIRST_BE = 2'h3;  // Big endian start
    localparam logic [1:0] SUB_ONE = 2'h1;       // Step size

    // ------------------------------------------------------------
    // Width modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WIDTH_LONG = 2'b00,
        WIDTH_WORD = 2'b01,
        WIDTH_BYTE = 2'b10
    } width_mode_e;

endpackage : width_match_pkg

// ==== rtl/width_mode_decode.sv ====
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Registered decode of the static width and order selects
// ----------------------------------------------------------------
module width_mode_decode
    import width_match_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic bus_match_sync_i,    // Synchronised match select
    input wire logic bus_width_sync_i,    // Synchronised width select
    input wire logic endian_sync_i,       // Synchronised order select
    output width_mode_e mode_o,           // Decoded width
    output logic big_endian_o             // Order, zero in long mode
);

    // Decoded next values
    width_mode_e nxt_mode;
    logic nxt_big;

    // Width table; match low with width high is not a legal strap
    // and falls back to long word, the safest full-width reading
    always_comb begin
        if (!bus_match_sync_i) begin
            nxt_mode = WIDTH_LONG;
        end else if (bus_width_sync_i) begin
            nxt_mode = WIDTH_BYTE;
        end else begin
            nxt_mode = WIDTH_WORD;
        end
        // Order pin has no effect in long-word width
        nxt_big = (nxt_mode != WIDTH_LONG) && endian_sync_i;
    end

    // Hold decoded mode
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_o <= WIDTH_LONG;
            big_endian_o <= 1'b0;
        end else begin
            mode_o <= nxt_mode;
            big_endian_o <= nxt_big;
        end
    end

endmodule : width_mode_decode

`default_nettype wire

// ==== rtl/right_port_bus_width_matcher.sv ====
`timescale 1ns/1ns
`default_nettype none


module right_port_bus_width_matcher
    import width_match_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    // Static selects from pins
    input wire logic bus_match_select_i,
    input wire logic bus_width_select_i,
    input wire logic endian_order_select_i,
    // Port transfer strobes (same clock, from port control logic)
    input wire logic xfer_i,              // One port transfer this cycle
    input wire logic write_i,             // Transfer is a write
    // Memory side
    input wire logic [WORD_W-1:0] mem_rdata_i, // Word at current address
    output logic [WORD_W-1:0] mem_wdata_o,     // Assembled write word
    output logic [LANES-1:0] mem_lane_we_o,    // Per-lane write pulse
    output logic word_done_o,                  // Last part of a word
    // Right port data pins
    input wire logic [WORD_W-1:0] right_port_data_lines_i,
    output logic [WORD_W-1:0] right_port_data_lines_o,
    output logic [WORD_W-1:0] right_port_data_lines_oe_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sel_meta_ff;    // First stage, read by second only
    logic [2:0] sel_sync_ff;    // Second stage

    // Two flops on the asynchronous strap pins
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sel_meta_ff <= 3'h0;
            sel_sync_ff <= 3'h0;
        end else begin
            sel_meta_ff <= {bus_match_select_i, bus_width_select_i,
                            endian_order_select_i};
            sel_sync_ff <= sel_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    width_mode_e mode;          // Current width
    logic big_endian;           // Current order

    width_mode_decode u_decode (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .bus_match_sync_i(sel_sync_ff[2]),
        .bus_width_sync_i(sel_sync_ff[1]),
        .endian_sync_i(sel_sync_ff[0]),
        .mode_o(mode),
        .big_endian_o(big_endian)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // First sub-count of a word for the given order
    function automatic logic [SUB_W-1:0] first_sub(input logic big);
        first_sub = big ? SUB_FIRST_BE : SUB_FIRST_LE;
    endfunction : first_sub

    // Last sub-count of a word for the given order
    function automatic logic [SUB_W-1:0] last_sub(input logic big);
        last_sub = big ? SUB_FIRST_LE : SUB_FIRST_BE;
    endfunction : last_sub

    // ------------------------------------------------------------
    // Sub-counter
    // ------------------------------------------------------------
    // Lane index kept in 9-bit units; word mode uses steps of two
    logic [SUB_W-1:0] sub_ff;
    logic [SUB_W-1:0] nxt_sub;
    logic [SUB_W-1:0] step;     // Lanes per transfer
    logic last_part;            // Current transfer ends the word
    width_mode_e mode_q_ff;     // Mode seen last cycle
    logic big_q_ff;             // Order seen last cycle

    always_comb begin
        step = (mode == WIDTH_WORD) ? 2'h2 : SUB_ONE;
        unique case (mode)
            WIDTH_LONG: last_part = 1'b1;
            WIDTH_WORD: last_part = big_endian ? (sub_ff == 2'h0)
                                               : (sub_ff == 2'h2);
            WIDTH_BYTE: last_part = (sub_ff == last_sub(big_endian));
            default: last_part = 1'b1;
        endcase
        if (mode != mode_q_ff || big_endian != big_q_ff) begin
            // Restart on any change of decoded width or order to stay aligned
            nxt_sub = (mode == WIDTH_WORD && big_endian) ? 2'h2
                                                         : first_sub(big_endian);
        end else if (xfer_i && mode != WIDTH_LONG) begin
            if (big_endian) begin
                nxt_sub = sub_ff - step;
            end else begin
                nxt_sub = sub_ff + step;
            end
        end else begin
            nxt_sub = sub_ff;
        end
    end

    // Advance once per transfer cycle in word and byte width, wrapping each word
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sub_ff <= SUB_FIRST_LE;
            mode_q_ff <= WIDTH_LONG;
            big_q_ff <= 1'b0;
        end else begin
            sub_ff <= nxt_sub;
            mode_q_ff <= mode;
            big_q_ff <= big_endian;
        end
    end

    // ------------------------------------------------------------
    // Read path: lane multiplexer onto the pins
    // ------------------------------------------------------------
    logic [WORD_W-1:0] nxt_pin_out;
    logic [WORD_W-1:0] nxt_pin_oe;
    logic [LANE_W-1:0] rd_lane [LANES];     // Word split in lanes

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign rd_lane[g] = mem_rdata_i[g*LANE_W +: LANE_W];
        end
    endgenerate

    always_comb begin
        nxt_pin_out = '0;
        nxt_pin_oe = '0;
        unique case (mode)
            WIDTH_LONG: begin
                nxt_pin_out = mem_rdata_i;
                nxt_pin_oe = {WORD_W{1'b1}};
            end
            WIDTH_WORD: begin
                // Half selected by sub-count bit one
                nxt_pin_out[HALF_W-1:0] =
                    {rd_lane[sub_ff | 2'h1], rd_lane[sub_ff & 2'h2]};
                nxt_pin_oe[HALF_W-1:0] = {HALF_W{1'b1}};
            end
            WIDTH_BYTE: begin
                nxt_pin_out[LANE_W-1:0] = rd_lane[sub_ff];
                nxt_pin_oe[LANE_W-1:0] = {LANE_W{1'b1}};
            end
            default: begin
                nxt_pin_out = '0;
                nxt_pin_oe = '0;
            end
        endcase
        // Only drive during a read transfer
        if (!xfer_i || write_i) begin
            nxt_pin_oe = '0;
        end
    end

    // Registered pin drivers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            right_port_data_lines_o <= '0;
            right_port_data_lines_oe_o <= '0;
        end else begin
            right_port_data_lines_o <= nxt_pin_out;
            right_port_data_lines_oe_o <= nxt_pin_oe;
        end
    end

    // ------------------------------------------------------------
    // Write path: steer narrow data into its word portion
    // ------------------------------------------------------------
    logic [WORD_W-1:0] nxt_wdata;
    logic [LANES-1:0] nxt_we;

    always_comb begin
        nxt_wdata = mem_wdata_o;
        nxt_we = '0;
        if (xfer_i && write_i) begin
            unique case (mode)
                WIDTH_LONG: begin
                    nxt_wdata = right_port_data_lines_i;
                    nxt_we = 4'hF;
                end
                WIDTH_WORD: begin
                    // Low pins land in the half the sub-count names
                    nxt_wdata[sub_ff*LANE_W +: HALF_W] =
                        right_port_data_lines_i[HALF_W-1:0];
                    nxt_we = (sub_ff[1]) ? 4'hC : 4'h3;
                end
                WIDTH_BYTE: begin
                    nxt_wdata[sub_ff*LANE_W +: LANE_W] =
                        right_port_data_lines_i[LANE_W-1:0];
                    nxt_we[sub_ff] = 1'b1;
                end
                default: begin
                    nxt_we = '0;
                end
            endcase
        end
    end

    // Write data, lane strobes and word completion
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mem_wdata_o <= '0;
            mem_lane_we_o <= '0;
            word_done_o <= 1'b0;
        end else begin
            mem_wdata_o <= nxt_wdata;
            mem_lane_we_o <= nxt_we;
            word_done_o <= xfer_i && last_part;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_long_ignores_order: assert property (@(posedge clk_i) disable iff (reset_i)
        mode == WIDTH_LONG |-> !big_endian)
        else $error("order active in long width");

    a_word_mode_decode: assert property (@(posedge clk_i) disable iff (reset_i)
        $stable(sel_sync_ff) && sel_sync_ff[2:1] == 2'b10 ##1 $stable(sel_sync_ff)
        |=> mode == WIDTH_WORD)
        else $error("word width not decoded");

    a_byte_mode_decode: assert property (@(posedge clk_i) disable iff (reset_i)
        $stable(sel_sync_ff) && sel_sync_ff[2:1] == 2'b11 ##1 $stable(sel_sync_ff)
        |=> mode == WIDTH_BYTE)
        else $error("byte width not decoded");

    a_word_pins_only: assert property (@(posedge clk_i) disable iff (reset_i)
        mode == WIDTH_WORD && $stable(mode)
        |=> right_port_data_lines_oe_o[WORD_W-1:HALF_W] == '0)
        else $error("upper half driven in word width");

    a_byte_pins_only: assert property (@(posedge clk_i) disable iff (reset_i)
        mode == WIDTH_BYTE && $stable(mode)
        |=> right_port_data_lines_oe_o[WORD_W-1:LANE_W] == '0)
        else $error("upper lanes driven in byte width");

    a_read_lane_data: assert property (@(posedge clk_i) disable iff (reset_i)
        xfer_i && !write_i && mode == WIDTH_BYTE
        |=> right_port_data_lines_o[LANE_W-1:0] == LANE_W'(
            $past(mem_rdata_i) >> ($past(sub_ff) * LANE_W)))
        else $error("wrong lane on pins");

    a_sub_count_dir: assert property (@(posedge clk_i) disable iff (reset_i)
        xfer_i && mode == WIDTH_BYTE && $stable(mode) && $stable(big_endian)
        |=> sub_ff == ($past(big_endian) ? $past(sub_ff) - 2'h1
                                         : $past(sub_ff) + 2'h1))
        else $error("sub-counter stepped wrong way");

    a_word_two_parts: assert property (@(posedge clk_i) disable iff (reset_i)
        xfer_i && mode == WIDTH_WORD && sub_ff == first_sub(1'b0)
        && !big_endian && $stable(mode) && $stable(big_endian)
        ##1 xfer_i && $stable(mode) && $stable(big_endian)
        |=> word_done_o)
        else $error("word not done after two halves");

    a_long_no_step: assert property (@(posedge clk_i) disable iff (reset_i)
        xfer_i && mode == WIDTH_LONG && $stable(mode)
        |=> $stable(sub_ff))
        else $error("sub-counter stepped in long width");

    a_byte_one_lane: assert property (@(posedge clk_i) disable iff (reset_i)
        xfer_i && write_i && mode == WIDTH_BYTE
        |=> $onehot(mem_lane_we_o))
        else $error("byte write not on one lane");

    a_word_half_lanes: assert property (@(posedge clk_i) disable iff (reset_i)
        xfer_i && write_i && mode == WIDTH_WORD
        |=> mem_lane_we_o == 4'h3 || mem_lane_we_o == 4'hC)
        else $error("word write not on one half");

    a_byte_big_start: assert property (@(posedge clk_i) disable iff (reset_i)
        mode == WIDTH_BYTE && big_endian && $changed(big_endian)
        |=> sub_ff == SUB_FIRST_BE)
        else $error("big endian byte not started at top lane");

    a_word_big_start: assert property (@(posedge clk_i) disable iff (reset_i)
        mode == WIDTH_WORD && big_endian && $changed(big_endian)
        |=> sub_ff == 2'h2)
        else $error("big endian word not started at top half");

endmodule : right_port_bus_width_matcher

`default_nettype wire

// ==== test/host_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Host side of the right-port data pins
// ------------------------------------------------------------
module host_pin_model
    import width_match_pkg::*;
(
    input wire logic clk_i,
    input wire logic drive_i,              // Host drives write data
    input wire logic [WORD_W-1:0] wdata_i, // Value put on the lines
    output logic [WORD_W-1:0] pins_o       // Host contribution to wire
);
    logic [WORD_W-1:0] last_ff = '0; // Last level the host put on the lines

    // Released lines toggle so a stale value never looks valid
    always @(posedge clk_i) begin
        if (drive_i) begin
            last_ff <= wdata_i;
        end else begin
            last_ff <= ~last_ff;
        end
    end

    // Lines always at a firm level, never left floating
    assign pins_o = drive_i ? wdata_i : ~last_ff;
endmodule : host_pin_model

`default_nettype wire

// ==== test/tb_right_port_bus_width_matcher.sv ====
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench for the width matcher
// ------------------------------------------------------------
module tb_right_port_bus_width_matcher;
    import width_match_pkg::*;

    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic bus_match_select_i = 1'b0;
    logic bus_width_select_i = 1'b0;
    logic endian_order_select_i = 1'b0;
    logic xfer_i = 1'b0;
    logic write_i = 1'b0;
    logic [WORD_W-1:0] mem_rdata_i = '0;
    logic [WORD_W-1:0] mem_wdata_o;
    logic [LANES-1:0] mem_lane_we_o;
    logic word_done_o;
    logic [WORD_W-1:0] pin_wire;   // Resolved level of the lines
    logic [WORD_W-1:0] right_port_data_lines_o;
    logic [WORD_W-1:0] right_port_data_lines_oe_o;
    logic [WORD_W-1:0] host_pins;  // Host contribution
    logic host_drive = 1'b0;       // Host drives during writes only
    logic [WORD_W-1:0] host_data = '0;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    // Free-running clock
    always #5 clk_i = ~clk_i;

    // Wire level from the DUT's enables; host fills the rest
    assign pin_wire = (right_port_data_lines_oe_o & right_port_data_lines_o)
        | (~right_port_data_lines_oe_o & host_pins);

    right_port_bus_width_matcher i_dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .bus_match_select_i(bus_match_select_i),
        .bus_width_select_i(bus_width_select_i),
        .endian_order_select_i(endian_order_select_i),
        .xfer_i(xfer_i),
        .write_i(write_i),
        .mem_rdata_i(mem_rdata_i),
        .mem_wdata_o(mem_wdata_o),
        .mem_lane_we_o(mem_lane_we_o),
        .word_done_o(word_done_o),
        .right_port_data_lines_i(pin_wire),
        .right_port_data_lines_o(right_port_data_lines_o),
        .right_port_data_lines_oe_o(right_port_data_lines_oe_o)
    );

    host_pin_model i_host (
        .clk_i(clk_i),
        .drive_i(host_drive),
        .wdata_i(host_data),
        .pins_o(host_pins)
    );

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    // Hang guard, over fifteen times the longest possible run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("mismatch at %0t: timeout", $time);
            close_out();
        end
    end

    // Straps then settle time for sync, decode and counter restart
    task automatic set_mode(input logic bm, input logic bw, input logic be);
        // Quiet port while straps settle, or the lane counter drifts
        xfer_i = 1'b0;
        write_i = 1'b0;
        bus_match_select_i = bm;
        bus_width_select_i = bw;
        endian_order_select_i = be;
        repeat (6) @(negedge clk_i);
    endtask : set_mode

    // One part of a word; expected lane from part index and order
    task automatic part(input bit wr, input int p, input int n,
                        input bit be, input logic [WORD_W-1:0] word);
        int w;
        int k;
        logic [WORD_W-1:0] msk;
        logic [WORD_W-1:0] lane;
        logic [LANES-1:0] we;
        w = WORD_W / n;
        k = be ? n - 1 - p : p;
        msk = (36'h1 << w) - 36'h1;
        lane = (word >> (k * w)) & msk;
        we = (n == 4) ? 4'h1 << k : (n == 2) ? 4'h3 << (2 * k) : 4'hF;
        xfer_i = 1'b1;
        write_i = wr;
        mem_rdata_i = word;
        host_drive = wr;
        host_data = lane;
        @(posedge clk_i);
        @(negedge clk_i);
        host_drive = 1'b0;
        if (wr) begin
            chk(mem_lane_we_o === we, "lane write strobe");
            chk(((mem_wdata_o >> (k * w)) & msk) === lane, "write lane");
        end else begin
            chk(right_port_data_lines_oe_o === msk, "pin enables");
            chk((right_port_data_lines_o & msk) === lane, "read lane");
        end
        chk(word_done_o === (p == n - 1), "word done");
    endtask : part

    // ------------------------------------------------------------
    // Main sequence: every width with both orders
    // ------------------------------------------------------------
    initial begin
        int n;
        bit wr;
        bit bw;
        logic [WORD_W-1:0] word;
        void'($urandom(32'h24BF5315));
        repeat (4) @(negedge clk_i);
        reset_i = 1'b0;
        for (int m = 0; m < 7; m++) begin
            // Last pass uses the illegal strap, which reads as long width
            n = (m < 2 || m == 6) ? 1 : (m < 4) ? 2 : 4;
            bw = (n == 4 || m == 6);
            // Long mode runs with both endian levels, result unchanged
            set_mode(n != 1, bw, m[0]);
            repeat (4) begin
                word = {4'($urandom), $urandom};
                wr = 1'($urandom);
                // Turnaround: a read's pin enables must fall before
                // the host drives the lines
                if (wr) begin
                    xfer_i = 1'b0;
                    @(negedge clk_i);
                end
                // Address held in increment mode across the parts
                for (int p = 0; p < n; p++) begin
                    part(wr, p, n, m[0], word);
                    // Random idle gap must not step the lane
                    if ($urandom % 3 == 0) begin
                        xfer_i = 1'b0;
                        @(negedge clk_i);
                        chk(word_done_o === 1'b0, "idle gap done");
                    end
                end
            end
        end
        xfer_i = 1'b0;
        close_out();
    end
endmodule : tb_right_port_bus_width_matcher

`default_nettype wire
